// [rxflt_pkg.sv]
// shared constants and carrier types for the receive address filter control
package rxflt_pkg;
  // register bus byte offsets
  localparam logic [7:0]  CTRL_OFS   = 8'h48;  // filter_control_register
  localparam logic [7:0]  DATA_OFS   = 8'h4c;  // filter_data_window
  // control register field positions
  localparam int          EN_BIT     = 31;     // filter_enable
  localparam int          AAB_BIT    = 30;     // broadcast_accept_all
  localparam int          AAM_BIT    = 29;     // multicast_accept_all
  localparam int          AAU_BIT    = 28;     // unicast_accept_all
  localparam int          APM_BIT    = 27;     // exact_match_accept
  localparam int          PAT_LO     = 23;     // pattern_accept_enables low bit
  localparam int          ARP_BIT    = 22;     // arp_accept
  localparam int          MH_BIT     = 21;     // multicast_hash_accept
  localparam int          UH_BIT     = 20;     // unicast_hash_accept
  localparam int          ULM_BIT    = 19;     // local_bit_ignore
  localparam int          PTR_W      = 10;     // filter_pointer width
  localparam int          MEM_SEL    = 9;      // pointer bit selecting filter memory
  localparam logic [31:0] CTRL_WMASK = 32'hfff803ff;  // unused 18..10 stay zero
  localparam logic [31:0] CTRL_RST   = 32'h00000000;
  // filter pointer decode
  localparam logic [9:0]  PTR_EXACT0 = 10'h000;
  localparam logic [9:0]  PTR_EXACT1 = 10'h002;
  localparam logic [9:0]  PTR_EXACT2 = 10'h004;
  localparam logic [9:0]  PTR_CNT01  = 10'h006;
  localparam logic [9:0]  PTR_CNT23  = 10'h008;
  localparam logic [9:0]  PTR_PW0    = 10'h00a;
  localparam logic [9:0]  PTR_PW1    = 10'h00c;
  localparam logic [9:0]  PTR_PW2    = 10'h00e;
  // data window layout
  localparam int          DATA_W     = 16;     // filter_data_bits
  localparam int          WORD_W     = 18;     // data plus byte_mask_bits
  localparam int          MASK0_BIT  = 16;     // mask for byte 0
  localparam int          MASK1_BIT  = 17;     // mask for byte 1
  // filter memory word indices (pointer bits 8..1)
  localparam logic [7:0]  PAT01_BASE = 8'h40;  // pointer 280h
  localparam logic [7:0]  PAT23_BASE = 8'h80;  // pointer 300h
  // frame decode
  localparam logic [15:0] ARP_TYPE   = 16'h0806;
  localparam logic [7:0]  DA_LAST    = 8'h05;
  localparam logic [7:0]  TYPE_HI    = 8'h0c;
  localparam logic [7:0]  TYPE_LO    = 8'h0d;
  localparam logic [7:0]  CNT_SAT    = 8'hff;
  localparam logic [47:0] ULM_MASK   = 48'h000000000002;  // u/l bit of octet 0
  localparam logic [47:0] BCAST_DA   = 48'hffffffffffff;

  // register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rxflt_req_s;

  // one received byte from the frame path
  typedef struct packed {
    logic        valid;
    logic        sof;
    logic        eof;
    logic [7:0]  data;
  } rxflt_beat_s;
endpackage

// [rxflt_addr_class.sv]
// destination address classifier and exact-match comparator
module rxflt_addr_class (
  // address inputs
  input  wire logic [47:0] da_i,
  input  wire logic [47:0] exact_i,
  input  wire logic        ulm_i,
  // classification
  output logic             bcast_o,
  output logic             mcast_o,
  output logic             ucast_o,
  output logic             exact_hit_o
);
  import rxflt_pkg::*;

  logic [47:0] cmp_mask;  // bits taking part in exact compare

  // octet 0 sits in the low byte, as received first on the wire
  always_comb begin
    cmp_mask    = ulm_i ? ~ULM_MASK : ~48'h000000000000;
    bcast_o     = (da_i == BCAST_DA);
    mcast_o     = da_i[0] && !bcast_o;
    ucast_o     = !da_i[0];
    exact_hit_o = ((da_i ^ exact_i) & cmp_mask) == 48'h000000000000;
  end
endmodule

// [rxflt_pat_match.sv]
// one pattern buffer comparator, fed one template byte per frame byte
module rxflt_pat_match #(
  parameter int IDX_W = 8
) (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             sys_rst_i,
  // frame byte and its position
  input  wire logic             valid_i,
  input  wire logic             sof_i,
  input  wire logic [IDX_W-1:0] idx_i,
  input  wire logic [7:0]       byte_i,
  // template byte, its mask and the compare length
  input  wire logic [7:0]       tmpl_i,
  input  wire logic             mask_i,
  input  wire logic [IDX_W-1:0] count_i,
  // result for the frame so far
  output logic                  hit_o
);
  logic ok_q;   // no mismatch inside the compared bytes yet
  logic len_q;  // frame has reached the compare length
  logic byte_ok;

  // a masked byte or one past the count always matches
  assign byte_ok = (idx_i >= count_i) || mask_i || (byte_i == tmpl_i);

  // track mismatch and length, restarting on each first byte
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ok_q  <= 1'b0;
      len_q <= 1'b0;
    end else if (valid_i) begin
      ok_q  <= (sof_i || ok_q) && byte_ok;
      len_q <= (IDX_W'(idx_i + 1'b1) >= count_i) || (sof_i ? 1'b0 : len_q);
    end
  end

  assign hit_o = ok_q && len_q;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  miss_clears_a: assert property (valid_i && !mask_i && idx_i < count_i
                                  && byte_i != tmpl_i |=> !hit_o)
    else $error("pattern mismatch did not clear the hit");
endmodule

// [rxflt_ctrl.sv]
// receive filter control register, indirect filter registers and accept decision
//
// The implementer's own choice: the address-and-strobe port.
module rxflt_ctrl #(
  parameter int MEM_DEPTH = 256,  // filter memory words
  parameter int NUM_PAT   = 4     // pattern buffers
) (
  // clock and resets
  input  wire logic                    sys_clk_i,
  input  wire logic                    sys_rst_i,
  input  wire logic                    soft_rst_i,
  // register port
  input  wire rxflt_pkg::rxflt_req_s   bus_req_i,
  output logic [31:0]                  bus_rdata_o,
  // receive frame path
  input  wire rxflt_pkg::rxflt_beat_s  rx_beat_i,
  input  wire logic [8:0]              rx_hash_idx_i,
  // accept decision
  output logic                         verdict_valid_o,
  output logic                         verdict_accept_o
);
  import rxflt_pkg::*;

  localparam int MEM_AW = $clog2(MEM_DEPTH);

  // control register and its fields
  logic [31:0]         ctrl_q;
  logic                filt_en;
  logic [NUM_PAT-1:0]  pat_en;
  logic [PTR_W-1:0]    ptr;
  // indirect registers
  logic [15:0]         exact_q [3];  // exact_address_register pairs
  logic [15:0]         pw_q    [3];  // wake_password pairs
  logic [15:0]         cnt_q   [2];  // pattern_length_registers pairs
  logic [47:0]         exact_flat;
  // filter memory: hash table then pattern buffers, 18-bit words
  logic [WORD_W-1:0]   mem [MEM_DEPTH];
  logic [MEM_AW-1:0]   mem_idx;
  // bus decode
  logic                wr_ctrl;
  logic                wr_data;
  logic [31:0]         rd_word;
  logic [31:0]         win_word;
  logic [31:0]         rdata_q;
  // frame capture
  logic [7:0]          cnt_byte_q;  // saturating byte position
  logic [7:0]          idx;
  logic [47:0]         da_q;
  logic [15:0]         type_q;
  logic [8:0]          hash_q;
  logic                decide_q;
  // classification and hits
  logic                is_bc;
  logic                is_mc;
  logic                is_uc;
  logic                exact_hit;
  logic                hash_hit;
  logic [15:0]         hash_word;
  logic [NUM_PAT-1:0]  pat_hit;
  logic                arp_hit;
  logic                accept;
  logic                acc_q;
  logic                vld_q;

  assign filt_en    = ctrl_q[EN_BIT];
  assign pat_en     = ctrl_q[PAT_LO +: NUM_PAT];
  assign ptr        = ctrl_q[PTR_W-1:0];
  assign mem_idx    = ptr[MEM_AW:1];
  assign exact_flat = {exact_q[2], exact_q[1], exact_q[0]};
  assign wr_ctrl    = bus_req_i.wr && (bus_req_i.addr == CTRL_OFS);
  assign wr_data    = bus_req_i.wr && (bus_req_i.addr == DATA_OFS);

  // control register; software is expected to drop enable first
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || soft_rst_i) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= bus_req_i.wdata & CTRL_WMASK;
    end
  end

  // indirect registers written through the data window
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 3; i++) begin
        exact_q[i] <= 16'h0000;
        pw_q[i]    <= 16'h0000;
      end
      cnt_q[0] <= 16'h0000;
      cnt_q[1] <= 16'h0000;
    end else if (wr_data) begin
      case (ptr)
        PTR_EXACT0: exact_q[0] <= bus_req_i.wdata[DATA_W-1:0];
        PTR_EXACT1: exact_q[1] <= bus_req_i.wdata[DATA_W-1:0];
        PTR_EXACT2: exact_q[2] <= bus_req_i.wdata[DATA_W-1:0];
        PTR_CNT01:  cnt_q[0]   <= bus_req_i.wdata[DATA_W-1:0];
        PTR_CNT23:  cnt_q[1]   <= bus_req_i.wdata[DATA_W-1:0];
        PTR_PW0:    pw_q[0]    <= bus_req_i.wdata[DATA_W-1:0];
        PTR_PW1:    pw_q[1]    <= bus_req_i.wdata[DATA_W-1:0];
        PTR_PW2:    pw_q[2]    <= bus_req_i.wdata[DATA_W-1:0];
        default: begin
          // memory and unmapped pointers leave these alone
        end
      endcase
    end
  end

  // filter memory write; no reset, software loads it before enabling
  always_ff @(posedge sys_clk_i) begin
    if (wr_data && ptr[MEM_SEL]) begin
      mem[mem_idx] <= bus_req_i.wdata[WORD_W-1:0];
    end
  end

  // data window read mux; unmapped pointers read zero
  always_comb begin
    win_word = 32'h00000000;
    if (ptr[MEM_SEL]) begin
      win_word[WORD_W-1:0] = mem[mem_idx];
    end else begin
      case (ptr)
        PTR_EXACT0: win_word[DATA_W-1:0] = exact_q[0];
        PTR_EXACT1: win_word[DATA_W-1:0] = exact_q[1];
        PTR_EXACT2: win_word[DATA_W-1:0] = exact_q[2];
        PTR_CNT01:  win_word[DATA_W-1:0] = cnt_q[0];
        PTR_CNT23:  win_word[DATA_W-1:0] = cnt_q[1];
        PTR_PW0:    win_word[DATA_W-1:0] = pw_q[0];
        PTR_PW1:    win_word[DATA_W-1:0] = pw_q[1];
        PTR_PW2:    win_word[DATA_W-1:0] = pw_q[2];
        default:    win_word = 32'h00000000;
      endcase
    end
  end

  // register offset decode; unmapped offsets read zero
  always_comb begin
    case (bus_req_i.addr)
      CTRL_OFS: rd_word = ctrl_q;
      DATA_OFS: rd_word = win_word;
      default:  rd_word = 32'h00000000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= bus_req_i.rd ? rd_word : 32'h00000000;
    end
  end

  assign bus_rdata_o = rdata_q;

  // byte position within the frame, first byte is zero
  assign idx = rx_beat_i.sof ? 8'h00 : cnt_byte_q;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cnt_byte_q <= 8'h00;
    end else if (rx_beat_i.valid) begin
      // saturate so a long frame never wraps back into the header
      cnt_byte_q <= (idx == CNT_SAT) ? CNT_SAT : 8'(idx + 8'h01);
    end
  end

  // capture destination address, octet k into byte lane k
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      da_q <= 48'h000000000000;
    end else if (rx_beat_i.valid && idx <= DA_LAST) begin
      da_q[idx[2:0]*8 +: 8] <= rx_beat_i.data;
    end
  end

  // capture type/length field, cleared at each frame start
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      type_q <= 16'h0000;
    end else if (rx_beat_i.valid) begin
      if (idx == TYPE_HI) begin
        type_q[15:8] <= rx_beat_i.data;
      end else if (idx == TYPE_LO) begin
        type_q[7:0] <= rx_beat_i.data;
      end else if (rx_beat_i.sof) begin
        type_q <= 16'h0000;
      end
    end
  end

  // decision is taken the cycle after the last byte
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      decide_q <= 1'b0;
      hash_q   <= 9'h000;
    end else begin
      decide_q <= rx_beat_i.valid && rx_beat_i.eof;
      if (rx_beat_i.valid && rx_beat_i.eof) begin
        hash_q <= rx_hash_idx_i;
      end
    end
  end

  rxflt_addr_class u_class (
    .da_i        (da_q),
    .exact_i     (exact_flat),
    .ulm_i       (ctrl_q[ULM_BIT]),
    .bcast_o     (is_bc),
    .mcast_o     (is_mc),
    .ucast_o     (is_uc),
    .exact_hit_o (exact_hit)
  );

  // hash table: 32 words of 16 bits at the bottom of memory
  assign hash_word = mem[MEM_AW'(hash_q[8:4])][DATA_W-1:0];
  assign hash_hit  = hash_word[hash_q[3:0]];

  // one comparator per pattern buffer, template words interleaved in pairs
  for (genvar b = 0; b < NUM_PAT; b++) begin : g_pat
    logic [MEM_AW-1:0] tw_idx;
    logic [WORD_W-1:0] tw;
    assign tw_idx = MEM_AW'((b < 2) ? PAT01_BASE : PAT23_BASE)
                    + MEM_AW'({idx[6:1], 1'(b % 2)});
    assign tw     = mem[tw_idx];
    rxflt_pat_match #(
      .IDX_W (8)
    ) u_pat (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .valid_i   (rx_beat_i.valid),
      .sof_i     (rx_beat_i.sof),
      .idx_i     (idx),
      .byte_i    (rx_beat_i.data),
      .tmpl_i    (idx[0] ? tw[15:8] : tw[7:0]),
      .mask_i    (idx[0] ? tw[MASK1_BIT] : tw[MASK0_BIT]),
      .count_i   (cnt_q[b / 2][8 * (b % 2) +: 8]),
      .hit_o     (pat_hit[b])
    );
  end

  assign arp_hit = ctrl_q[ARP_BIT] && (type_q == ARP_TYPE);

  // any enabled criterion accepts; disabled filter rejects all
  always_comb begin
    accept = (is_bc && ctrl_q[AAB_BIT])
          || (is_mc && ctrl_q[AAM_BIT])
          || (is_mc && ctrl_q[MH_BIT] && hash_hit)
          || (is_uc && ctrl_q[AAU_BIT])
          || (is_uc && ctrl_q[UH_BIT] && hash_hit)
          || (ctrl_q[APM_BIT] && !is_bc && exact_hit)
          || |(pat_en & pat_hit)
          || arp_hit;
    accept = accept && filt_en;
  end

  // verdict pulse registered from the decision cycle
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      vld_q <= 1'b0;
      acc_q <= 1'b0;
    end else begin
      vld_q <= decide_q;
      acc_q <= decide_q && accept;
    end
  end

  assign verdict_valid_o  = vld_q;
  assign verdict_accept_o = acc_q;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  disabled_reject_a: assert property (decide_q && !filt_en
                                      |=> verdict_valid_o && !verdict_accept_o)
    else $error("packet accepted with filter disabled");
  bcast_accept_a: assert property (decide_q && filt_en && is_bc && ctrl_q[AAB_BIT]
                                   |=> verdict_accept_o)
    else $error("broadcast not accepted");
  mcast_all_a: assert property (decide_q && filt_en && is_mc && ctrl_q[AAM_BIT]
                                |=> verdict_accept_o)
    else $error("multicast not accepted");
  ucast_all_a: assert property (decide_q && filt_en && is_uc && ctrl_q[AAU_BIT]
                                |=> verdict_accept_o)
    else $error("unicast not accepted");
  exact_match_a: assert property (decide_q && filt_en && ctrl_q[APM_BIT]
                                  && !is_bc && da_q == exact_flat |=> verdict_accept_o)
    else $error("exact address not accepted");
  arp_accept_a: assert property (decide_q && filt_en && ctrl_q[ARP_BIT]
                                 && type_q == ARP_TYPE |=> verdict_accept_o)
    else $error("arp frame not accepted");
  mhash_hit_a: assert property (decide_q && filt_en && is_mc && ctrl_q[MH_BIT]
                                && hash_hit |=> verdict_accept_o)
    else $error("multicast hash hit not accepted");
  uhash_hit_a: assert property (decide_q && filt_en && is_uc && ctrl_q[UH_BIT]
                                && hash_hit |=> verdict_accept_o)
    else $error("unicast hash hit not accepted");
  none_reject_a: assert property (decide_q && !is_bc && !ctrl_q[AAM_BIT]
                                  && !ctrl_q[AAU_BIT] && !ctrl_q[APM_BIT] && pat_en == '0
                                  && !ctrl_q[ARP_BIT] && !ctrl_q[MH_BIT] && !ctrl_q[UH_BIT]
                                  |=> !verdict_accept_o)
    else $error("packet accepted with no criterion");
  unused_zero_a: assert property (bus_req_i.rd && bus_req_i.addr == CTRL_OFS
                                  |=> bus_rdata_o[18:10] == 9'h000)
    else $error("unused control bits read nonzero");
  soft_clear_a: assert property (soft_rst_i |=> ctrl_q == CTRL_RST)
    else $error("soft reset did not clear control");
  exact_write_a: assert property (wr_data && ptr == PTR_EXACT0
                                  |=> exact_q[0] == $past(bus_req_i.wdata[15:0]))
    else $error("exact pair 1-0 not written");

  bcast_seen_c: cover property (decide_q && is_bc ##1 verdict_accept_o);
  pat_seen_c:   cover property (decide_q && |(pat_en & pat_hit) ##1 verdict_accept_o);
  arp_seen_c:   cover property (decide_q && arp_hit ##1 verdict_accept_o);
  reject_c:     cover property (decide_q && filt_en ##1 !verdict_accept_o);
endmodule

// [rxflt_frame_src.sv]
// behavioural receive frame source standing in for the mac frame path
module rxflt_frame_src (
  // clock
  input  wire logic                   sys_clk_i,
  // frame request from the bench
  input  wire logic                   start_i,
  input  wire logic                   slow_i,
  input  wire logic [47:0]            da_i,
  input  wire logic [15:0]            type_i,
  input  wire logic [7:0]             len_i,
  input  wire logic [8:0]             hash_i,
  // frame path toward the filter
  output rxflt_pkg::rxflt_beat_s      beat_o,
  output logic [8:0]                  hash_o
);
  import rxflt_pkg::*;

  // byte k of the frame: da first octet on the wire first, type at 12 and 13
  function automatic logic [7:0] byte_at(input int k);
    if (k < 6) return da_i[47-8*k -: 8];
    if (k == 12) return type_i[15:8];
    if (k == 13) return type_i[7:0];
    return 8'h30 + k[7:0];  // source address and payload filler
  endfunction

  // one frame per start pulse; slow mode leaves an idle slot after each byte
  initial begin
    beat_o <= '0;
    hash_o <= '1;
    forever begin
      @(posedge sys_clk_i);
      if (start_i) begin
        for (int k = 0; k < int'(len_i); k++) begin
          beat_o <= '{1'b1, k == 0, k == int'(len_i) - 1, byte_at(k)};
          hash_o <= hash_i;
          @(posedge sys_clk_i);
          if (slow_i) begin
            // idle lane shows a changing value so stale data is never reused
            beat_o <= '{1'b0, 1'b0, 1'b0, ~beat_o.data};
            @(posedge sys_clk_i);
          end
        end
        beat_o <= '{1'b0, 1'b0, 1'b0, ~beat_o.data};
        hash_o <= ~hash_o;  // index only holds while the frame's bytes are sent
      end
    end
  end
endmodule

// [rxflt_ctrl_bench.sv]
// self-checking bench for the receive filter control block
module rxflt_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import rxflt_pkg::*;

  // control bit values
  localparam logic [31:0] EN  = 32'h1 << EN_BIT;
  localparam logic [31:0] AB  = 32'h1 << AAB_BIT;
  localparam logic [31:0] AM  = 32'h1 << AAM_BIT;
  localparam logic [31:0] AU  = 32'h1 << AAU_BIT;
  localparam logic [31:0] PM  = 32'h1 << APM_BIT;
  localparam logic [31:0] P0  = 32'h1 << PAT_LO;
  localparam logic [31:0] AR  = 32'h1 << ARP_BIT;
  localparam logic [31:0] MH  = 32'h1 << MH_BIT;
  localparam logic [31:0] UH  = 32'h1 << UH_BIT;
  localparam logic [31:0] UL  = 32'h1 << ULM_BIT;
  localparam logic [47:0] UNI = 48'h020000000001;  // unicast, matches nothing set up

  // design and model signals
  logic        sys_clk;
  logic        sys_rst;
  logic        soft_rst;
  rxflt_req_s  req;
  logic [31:0] rdata;
  rxflt_beat_s beat;
  logic [8:0]  hash;
  logic        vvalid;
  logic        vaccept;
  logic        start;
  logic        slow;
  logic [47:0] da;
  logic [15:0] typ;
  logic [8:0]  hidx;
  int          n_errors;
  int          cmp_count;
  logic [31:0] ctrl_now;  // last control value the bench left in place

  rxflt_ctrl dut_u (
    .sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .soft_rst_i(soft_rst),
    .bus_req_i(req), .bus_rdata_o(rdata), .rx_beat_i(beat), .rx_hash_idx_i(hash),
    .verdict_valid_o(vvalid), .verdict_accept_o(vaccept)
  );

  rxflt_frame_src src_u (
    .sys_clk_i(sys_clk), .start_i(start), .slow_i(slow), .da_i(da), .type_i(typ),
    .len_i(8'h10), .hash_i(hidx), .beat_o(beat), .hash_o(hash)
  );

  // 40 mhz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // bus write; a spare cycle keeps strobe edges apart
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    req <= '0;
    @(posedge sys_clk);
  endtask

  // bus read; data only stand in the cycle after the strobe, then fall to zero
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge sys_clk);
    req <= '0;
    #1 chk(rdata, exp, what);
    @(posedge sys_clk);
    #1 chk(rdata, 32'h0, "read data not cleared");
    @(posedge sys_clk);
  endtask

  // drop only the enable first, then change fields, enable last
  task automatic cfg(input logic [31:0] c);
    wr(CTRL_OFS, ctrl_now & ~EN);
    wr(CTRL_OFS, c & ~EN);
    wr(CTRL_OFS, c);
    ctrl_now = c;
  endtask

  // indirect register write through pointer and data window
  task automatic iw(input logic [9:0] p, input logic [31:0] d);
    wr(CTRL_OFS, ctrl_now & ~EN);
    wr(CTRL_OFS, {22'h0, p});
    wr(DATA_OFS, d);
    ctrl_now = {22'h0, p};
  endtask

  // set control, send one frame, judge the verdict
  task automatic tf(input logic [31:0] c, input logic [47:0] d, input logic [15:0] t,
                    input logic [8:0] h, input logic exp);
    int n;
    cfg(c);
    da <= d;
    typ <= t;
    hidx <= h;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1 n++;
    end while (vvalid !== 1'b1 && n < 100);
    chk({30'h0, vvalid, vaccept}, {30'h0, 1'b1, exp}, "verdict");
    @(posedge sys_clk);
  endtask

  // control register access kinds, unused bits, unmapped offset, soft reset
  task automatic t_regs();
    rdchk(CTRL_OFS, 32'h0, "control reset value");
    wr(8'h50, 32'hffffffff);
    rdchk(8'h50, 32'h0, "unmapped offset");
    wr(CTRL_OFS, 32'h7fffffff);
    rdchk(CTRL_OFS, 32'h7ff803ff, "unused bits");
    wr(CTRL_OFS, 32'hffffffff);
    rdchk(CTRL_OFS, 32'hfff803ff, "enable bit");
    soft_rst <= 1'b1;
    @(posedge sys_clk);
    soft_rst <= 1'b0;
    @(posedge sys_clk);
    rdchk(CTRL_OFS, 32'h0, "soft reset");
    $display("test regs done");
  endtask

  // every indirect register pointer, a memory word with masks, a hole
  task automatic t_ind();
    logic [31:0] v;
    for (int p = 0; p < 16; p += 2) begin
      v = {14'h0, 2'b11, 8'h10 + 8'(p), 8'h21 + 8'(p)};
      iw(10'(p), v);
      rdchk(DATA_OFS, v & 32'hffff, "indirect register");
    end
    iw(10'h3fe, 32'h0003a5c3);
    rdchk(DATA_OFS, 32'h0003a5c3, "filter memory word");
    iw(10'h010, 32'h1234);
    rdchk(DATA_OFS, 32'h0, "unmapped pointer");
    $display("test indirect done");
  endtask

  // broadcast, unicast, exact match and enable
  task automatic t_addr();
    iw(PTR_EXACT0, 32'h0008);
    iw(PTR_EXACT1, 32'h0717);
    iw(PTR_EXACT2, 32'h5528);
    tf(AB | AU | AM | PM, BCAST_DA, 16'h0800, 9'h0, 1'b0);
    tf(EN | AB, BCAST_DA, 16'h0800, 9'h0, 1'b1);
    tf(EN | AU | AM, BCAST_DA, 16'h0800, 9'h0, 1'b0);
    tf(EN | AU, UNI, 16'h0800, 9'h0, 1'b1);
    tf(EN | AB | AM, UNI, 16'h0800, 9'h0, 1'b0);
    tf(EN | PM, 48'h080017072855, 16'h0800, 9'h0, 1'b1);
    tf(EN, 48'h080017072855, 16'h0800, 9'h0, 1'b0);
    tf(EN | PM, 48'h552807170008, 16'h0800, 9'h0, 1'b0);
    tf(EN | PM, 48'h0a0017072855, 16'h0800, 9'h0, 1'b0);
    slow <= 1'b1;
    tf(EN | PM | UL, 48'h0a0017072855, 16'h0800, 9'h0, 1'b1);
    slow <= 1'b0;
    $display("test address done");
  endtask

  // arp type, multicast and unicast hash
  task automatic t_hash();
    iw(10'h202, 32'h0008);  // hash bit 013h set
    tf(EN, UNI, ARP_TYPE, 9'h0, 1'b0);
    tf(EN | AR, UNI, ARP_TYPE, 9'h0, 1'b1);
    tf(EN | AM, 48'h010000000005, 16'h0800, 9'h0, 1'b1);
    tf(EN | MH, 48'h010000000005, 16'h0800, 9'h013, 1'b1);
    tf(EN | MH, 48'h010000000005, 16'h0800, 9'h014, 1'b0);
    tf(EN, 48'h010000000005, 16'h0800, 9'h013, 1'b0);
    tf(EN | UH, UNI, 16'h0800, 9'h013, 1'b1);
    tf(EN | UH, UNI, 16'h0800, 9'h012, 1'b0);
    tf(EN | MH, UNI, 16'h0800, 9'h013, 1'b0);
    $display("test hash done");
  endtask

  // pattern buffers 0 to 3, counts of two
  task automatic t_pat();
    iw(PTR_CNT01, 32'h0202);
    iw(10'h280, 32'hbbaa);
    iw(10'h282, 32'h2211);
    tf(EN | P0, 48'haabb00000001, 16'h0800, 9'h0, 1'b1);
    tf(EN | P0, 48'haacc00000001, 16'h0800, 9'h0, 1'b0);
    tf(EN | (P0 << 1), 48'haabb00000001, 16'h0800, 9'h0, 1'b0);
    tf(EN | (P0 << 1), 48'h112200000001, 16'h0800, 9'h0, 1'b1);
    tf(EN, 48'haabb00000001, 16'h0800, 9'h0, 1'b0);
    iw(10'h280, 32'h1bbaa);  // byte 0 masked
    tf(EN | P0, 48'hccbb00000001, 16'h0800, 9'h0, 1'b1);
    iw(PTR_CNT23, 32'h0202);
    iw(10'h300, 32'hbbaa);
    iw(10'h302, 32'h2211);
    tf(EN | (P0 << 2), 48'haabb00000001, 16'h0800, 9'h0, 1'b1);
    tf(EN | (P0 << 3), 48'h112200000001, 16'h0800, 9'h0, 1'b1);
    tf(EN | (P0 << 3), 48'haabb00000001, 16'h0800, 9'h0, 1'b0);
    $display("test pattern done");
  endtask

  // verdict and end of run
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog, far beyond the thousand or so cycles the tests take
  initial begin
    #(25 * 20000);
    n_errors++;
    $display("BAD t=%0t watchdog expired", $time);
    end_sim();
  end

  // main sequence
  initial begin
    n_errors = 0;
    cmp_count = 0;
    ctrl_now = '0;
    sys_rst <= 1'b1;
    soft_rst <= 1'b0;
    req <= '0;
    start <= 1'b0;
    slow <= 1'b0;
    da <= '0;
    typ <= '0;
    hidx <= '0;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    t_regs();
    t_ind();
    t_addr();
    t_hash();
    t_pat();
    end_sim();
  end
endmodule
